// File: include/sfs_consts.svh
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SFS_OFF_CONFIG 12'h000
`define SFS_OFF_STATUS 12'h004
`define SFS_OFF_CMD 12'h008
`define SFS_OFF_LIVE 12'h00C

// ==========================================================
// Config register fields
`define SFS_CFG_BLANK_LSB 0
`define SFS_CFG_RETRY 2
`define SFS_CFG_OPENDLY_LSB 3
`define SFS_CFG_OPENLVL 5
`define SFS_CFG_FUNC_LSB 6
`define SFS_CFG_INHIBIT 8
`define SFS_CFG_WIDTH 9
`define SFS_CFG_RESET 9'h00A

// ==========================================================
// Status register fields
`define SFS_ST_POWER_UP 0
`define SFS_ST_RECORD 1
`define SFS_ST_HIGH_SUP 2
`define SFS_ST_LOW_SUP 3
`define SFS_ST_HEAT 4
`define SFS_ST_THERMAL 5
`define SFS_ST_OC_LSB 6
`define SFS_ST_OPEN_LSB 8
`define SFS_ST_WIDTH 10
`define SFS_ST_RESET 10'h003

// ==========================================================
// Command register bits (write-only pulses)
`define SFS_CMD_FAULT_RST 0
`define SFS_CMD_SINGLE_STEP 1
`define SFS_CMD_SEQ_START 2

// ==========================================================
// Timing
`define SFS_CLK_PERIOD_NS 50
`define SFS_BLANK_UNIT_NS 1000
`define SFS_OPEN_UNIT_MS 10
`define SFS_OPEN_LOW_MA 13
`define SFS_OPEN_HIGH_MA 26

`endif

// File: include/sfs_pkg.sv
package sfs_pkg;
  // Function shown on the fault output pin
  typedef enum logic [1:0] {
    SFS_FN_GENERAL,
    SFS_FN_SUPPLY,
    SFS_FN_OPEN,
    SFS_FN_HEAT
  } sfs_pin_fn_t;
endpackage : sfs_pkg

// File: design/sfs_supervisor.sv
// Overview of operation
// R1: Overvoltage disables bridge, faults pin, sets flag
// R2: Overvoltage clearing re-enables; flag stays set
// R3: Undervoltage disables, faults, sets low flag
// R4: Undervoltage above power-on keeps all registers
// R5: Pump undervoltage acts like main undervoltage
// R6: Power-on reset sets power-up and record bits
// R7: Supply faults pull pin in general/supply function
// R8: Heat warning flags only, bit stays set
// R9: Overtemperature disables outputs, bit stays set
// R10: Temperature faults pull pin in general function
// R11: Overcurrent ignored for selected 1-4 us blank
// R12: Blank timer restarts if condition drops early
// R13: Latched overcurrent disables affected phase outputs
// R14: Retry hold zero: every step clears overcurrent
// R15: Overcurrent clear re-enables, pin may rise
// R16: On-time limit handled like overcurrent
// R17: Retry hold one: steps keep overcurrent
// R18: Open load flagged below 13/26 mA threshold
// R19: Open check locked out 10-40 ms per step
// R20: Check phase only if target exceeds twice threshold
// R21: Bridge keeps driving; listed events clear open load
// R22: Step pin edge clears open load and advances
// R23: Pin defaults to general fault function
// R24: Bridge faults latched; supply/temperature faults static
// R25: All comparator flags pass two-flop synchronisers
`timescale 1ns/1ps
`include "sfs_consts.svh"
`default_nettype none

module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int BLANK_UNIT_CYC = `SFS_BLANK_UNIT_NS / `SFS_CLK_PERIOD_NS,
  parameter int OPEN_UNIT_CYC = (`SFS_OPEN_UNIT_MS * 1000000) / `SFS_CLK_PERIOD_NS,
  parameter int TARGET_W = 10
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Analogue comparator flags (asynchronous)
  input wire logic HIGH_SUPPLY_IN,
  input wire logic LOW_SUPPLY_IN,
  input wire logic PUMP_LOW_IN,
  input wire logic HEAT_WARN_IN,
  input wire logic OVER_TEMP_IN,
  input wire logic [1:0] OVERCURRENT_IN,
  input wire logic [1:0] ONTIME_MAX_IN,
  input wire logic [1:0] CURRENT_LOW_IN,
  input wire logic [1:0] PWM_THRESH_IN,
  input wire logic STEP_PIN_IN,
  // Same-domain inputs from sequencer and regulator
  input wire logic SEQ_STEP_IN,
  input wire logic [TARGET_W-1:0] TARGET_A_MA_IN,
  input wire logic [TARGET_W-1:0] TARGET_B_MA_IN,
  // Bridge and stepping controls
  output logic [1:0] BRIDGE_EN_OUT,
  output logic OPEN_LEVEL_SEL_OUT,
  output logic STEP_ADVANCE_OUT,
  // Open-drain fault pin
  output logic FAULT_PIN_O_OUT,
  output logic FAULT_PIN_OE_OUT
);

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw_flags; // Asynchronous comparator bundle
  logic [NSYNC-1:0] sync_meta; // First stage, read only by second
  logic [NSYNC-1:0] sync_flags; // Safe to use

  assign raw_flags = {STEP_PIN_IN, PWM_THRESH_IN, CURRENT_LOW_IN, ONTIME_MAX_IN,
                      OVERCURRENT_IN, OVER_TEMP_IN, HEAT_WARN_IN, PUMP_LOW_IN,
                      LOW_SUPPLY_IN, HIGH_SUPPLY_IN};

  // Two flops per comparator flag
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          sync_meta[gi] <= 1'b0;
          sync_flags[gi] <= 1'b0;
        end else begin
          sync_meta[gi] <= raw_flags[gi]; // [R25]
          sync_flags[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised bundle
  // Bit order must track the concatenation above
  wire s_high = sync_flags[0];
  wire s_low = sync_flags[1];
  wire s_pump = sync_flags[2];
  wire s_heat = sync_flags[3];
  wire s_temp = sync_flags[4];
  wire [1:0] s_oc = sync_flags[6:5];
  wire [1:0] s_ontime = sync_flags[8:7];
  wire [1:0] s_curlow = sync_flags[10:9];
  wire [1:0] s_pwmth = sync_flags[12:11];
  wire s_step_pin = sync_flags[13];

  // ==========================================================
  // Register state
  logic [`SFS_CFG_WIDTH-1:0] cfg; // Software configuration
  logic [`SFS_ST_WIDTH-1:0] status; // Sticky fault record
  logic [1:0] oc_fault; // Latched overcurrent per phase
  logic [1:0] open_fault; // Latched open load per phase
  logic step_pin_d; // Previous synced step pin level

  // ==========================================================
  // APB decode
  // Commit needs PREADY_OUT high, so a write never lands in the first access cycle
  wire apb_access = PSEL_IN & PENABLE_IN;
  wire apb_done = apb_access & PREADY_OUT;
  wire apb_wr = apb_done & PWRITE_IN;
  wire hit_cfg = (PADDR_IN == `SFS_OFF_CONFIG);
  wire hit_st = (PADDR_IN == `SFS_OFF_STATUS);
  wire hit_cmd = (PADDR_IN == `SFS_OFF_CMD);
  wire hit_live = (PADDR_IN == `SFS_OFF_LIVE);
  wire addr_ok = hit_cfg | hit_st | hit_cmd | hit_live;
  wire wr_cfg = apb_wr & hit_cfg;
  wire wr_st = apb_wr & hit_st;
  wire wr_cmd = apb_wr & hit_cmd;

  // ==========================================================
  // Configuration fields
  // Fields decode straight from the flops, no shadow copies
  wire [1:0] blank_sel = cfg[`SFS_CFG_BLANK_LSB +: 2];
  wire retry_hold = cfg[`SFS_CFG_RETRY];
  wire [1:0] open_dly = cfg[`SFS_CFG_OPENDLY_LSB +: 2];
  wire open_lvl = cfg[`SFS_CFG_OPENLVL];
  wire inhibit = cfg[`SFS_CFG_INHIBIT];
  sfs_pin_fn_t pin_fn;
  assign pin_fn = sfs_pin_fn_t'(cfg[`SFS_CFG_FUNC_LSB +: 2]);

  // ==========================================================
  // Step and clear events
  // Edge taken after the synchroniser: a pin pulse shorter than a clock may be lost
  wire pin_rise = s_step_pin & ~step_pin_d;
  wire cmd_single = wr_cmd & PWDATA_IN[`SFS_CMD_SINGLE_STEP];
  wire cmd_seq = wr_cmd & PWDATA_IN[`SFS_CMD_SEQ_START];
  wire cmd_reset = wr_cmd & PWDATA_IN[`SFS_CMD_FAULT_RST];
  wire any_step = pin_rise | cmd_single | SEQ_STEP_IN;
  wire next_advance = pin_rise | cmd_single; // [R22]
  // Inhibited command writes neither step-clear nor start a sequence clear
  wire open_step_clr = pin_rise | (cmd_single & ~inhibit) | (cmd_seq & ~inhibit); // [R21] [R22]
  wire oc_step_clr = any_step & ~retry_hold; // [R14] [R17]
  wire oc_clr = cmd_reset | oc_step_clr; // [R13]

  // ==========================================================
  // Static fault summary
  wire supply_fault = s_high | s_low | s_pump; // [R24]
  wire temp_fault = s_heat | s_temp; // [R24]
  wire [1:0] next_bridge_en;
  // Heat warning alone takes no protective action; open load keeps driving
  assign next_bridge_en = (supply_fault | s_temp) ? 2'b00 : ~oc_fault; // [R1] [R2] [R3] [R5] [R9] [R13] [R21]

  // ==========================================================
  // Overcurrent blanking, one timer per phase
  localparam int BLANK_W = $clog2(4 * BLANK_UNIT_CYC + 1);
  wire [BLANK_W-1:0] blank_len =
    BLANK_W'((32'(blank_sel) + 32'd1) * 32'(BLANK_UNIT_CYC)); // [R11]
  logic [BLANK_W-1:0] blank_cnt [2];
  wire [1:0] oc_set;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_oc
      wire expired = (blank_cnt[gi] >= blank_len);
      assign oc_set[gi] = (s_oc[gi] & expired) | s_ontime[gi]; // [R12] [R16]
      // Timer counts while condition present, drops to zero otherwise
      // Counter parks at expiry instead of wrapping back to zero
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          blank_cnt[gi] <= '0;
        end else if (!s_oc[gi]) begin
          blank_cnt[gi] <= '0; // [R12]
        end else if (!expired) begin
          blank_cnt[gi] <= blank_cnt[gi] + 1'b1;
        end
      end
      // Latch wins over a clear in the same cycle
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          oc_fault[gi] <= 1'b0;
        end else if (oc_set[gi]) begin
          oc_fault[gi] <= 1'b1; // [R12] [R24]
        end else if (oc_clr) begin
          oc_fault[gi] <= 1'b0; // [R14] [R15]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Open-load lockout, shared, restarted on every step
  localparam int LOCK_W = $clog2(4 * OPEN_UNIT_CYC + 1);
  wire [LOCK_W-1:0] lock_len =
    LOCK_W'((32'(open_dly) + 32'd1) * 32'(OPEN_UNIT_CYC)); // [R19]
  logic [LOCK_W-1:0] lock_cnt;
  wire lock_done = (lock_cnt >= lock_len);

  // Lockout counter
  // Limitation: one lockout serves both phases, so any step restarts both
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      lock_cnt <= '0;
    end else if (any_step) begin
      lock_cnt <= '0; // [R19]
    end else if (!lock_done) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Twice the threshold: 26 or 52 mA
  wire [TARGET_W-1:0] open_twice = open_lvl ? TARGET_W'(2 * `SFS_OPEN_HIGH_MA)
                                            : TARGET_W'(2 * `SFS_OPEN_LOW_MA); // [R18]
  wire [1:0] target_ok = {TARGET_B_MA_IN > open_twice, TARGET_A_MA_IN > open_twice}; // [R20]
  wire [1:0] open_set;
  wire [1:0] open_clr;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_open
      // A step restarts the lockout, so the comparator is not looked at in
      // that cycle; otherwise a still-low current would beat the step clear
      assign open_set[gi] = lock_done & ~any_step &
                            target_ok[gi] & s_curlow[gi]; // [R18] [R19] [R20] [R22]
      assign open_clr[gi] = open_step_clr | s_pwmth[gi] |
                            (lock_done & ~s_curlow[gi]); // [R21]
      // Set wins over any clear event
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          open_fault[gi] <= 1'b0;
        end else if (open_set[gi]) begin
          open_fault[gi] <= 1'b1; // [R24]
        end else if (open_clr[gi]) begin
          open_fault[gi] <= 1'b0; // [R21]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Sticky status: hardware set wins over write-one-to-clear
  // Fault record follows any live static or latched dynamic fault
  wire any_fault = supply_fault | temp_fault | (|oc_fault) | (|open_fault);
  wire [`SFS_ST_WIDTH-1:0] st_set;
  assign st_set[`SFS_ST_POWER_UP] = 1'b0;
  assign st_set[`SFS_ST_RECORD] = any_fault;
  assign st_set[`SFS_ST_HIGH_SUP] = s_high; // [R1]
  assign st_set[`SFS_ST_LOW_SUP] = s_low | s_pump; // [R3] [R5]
  assign st_set[`SFS_ST_HEAT] = s_heat; // [R8]
  assign st_set[`SFS_ST_THERMAL] = s_temp; // [R9]
  assign st_set[`SFS_ST_OC_LSB +: 2] = oc_set;
  assign st_set[`SFS_ST_OPEN_LSB +: 2] = open_set;
  wire [`SFS_ST_WIDTH-1:0] st_clr = wr_st ? PWDATA_IN[`SFS_ST_WIDTH-1:0] : '0;
  // Bits leave only by software; fault clearing never touches them
  wire [`SFS_ST_WIDTH-1:0] next_status = st_set | (status & ~st_clr); // [R2] [R8] [R9]

  // Status and configuration registers
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      status <= `SFS_ST_RESET; // [R6]
      cfg <= `SFS_CFG_RESET; // [R6] [R23]
    end else begin
      status <= next_status;
      // Undervoltage has no reset path here, so settings survive it
      cfg <= wr_cfg ? PWDATA_IN[`SFS_CFG_WIDTH-1:0] : cfg; // [R4]
    end
  end

  // ==========================================================
  // Fault pin function select (low = fault)
  // Heat warning counts toward the general fault but never stops the bridge
  logic next_pin_low;
  always_comb begin
    unique case (pin_fn)
      SFS_FN_GENERAL: next_pin_low = any_fault; // [R7] [R10] [R15] [R23]
      SFS_FN_SUPPLY: next_pin_low = supply_fault; // [R7]
      SFS_FN_OPEN: next_pin_low = |open_fault;
      SFS_FN_HEAT: next_pin_low = temp_fault;
    endcase
  end

  // ==========================================================
  // APB read mux
  // Unmapped and command reads return zero
  wire [31:0] live_word = {22'h00_0000, open_fault, oc_fault, s_temp, s_heat,
                           s_pump, s_low, s_high, 1'b0};
  wire [31:0] rd_word = hit_cfg ? {{(32-`SFS_CFG_WIDTH){1'b0}}, cfg} :
                        hit_st ? {{(32-`SFS_ST_WIDTH){1'b0}}, status} :
                        hit_live ? live_word : 32'h0000_0000;
  // One wait state: answer flops load on the first access cycle
  wire next_ready = apb_access & ~PREADY_OUT;

  // Bus answer flops
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= next_ready;
      PRDATA_OUT <= (next_ready & ~PWRITE_IN) ? rd_word : 32'h0000_0000;
      PSLVERR_OUT <= next_ready & ~addr_ok;
    end
  end

  // ==========================================================
  // Registered block outputs
  // One flop stage here keeps pin and bridge free of decode glitches
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      step_pin_d <= 1'b0;
      BRIDGE_EN_OUT <= 2'b00;
      OPEN_LEVEL_SEL_OUT <= 1'b0;
      STEP_ADVANCE_OUT <= 1'b0;
      FAULT_PIN_O_OUT <= 1'b0;
      FAULT_PIN_OE_OUT <= 1'b0;
    end else begin
      step_pin_d <= s_step_pin;
      BRIDGE_EN_OUT <= next_bridge_en;
      OPEN_LEVEL_SEL_OUT <= open_lvl; // [R18]
      STEP_ADVANCE_OUT <= next_advance; // [R22]
      FAULT_PIN_O_OUT <= 1'b0; // Open drain only ever pulls low
      FAULT_PIN_OE_OUT <= next_pin_low;
    end
  end

endmodule : sfs_supervisor

`default_nettype wire

// File: dv/sfs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port-level checks
module sfs_chk (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  // Bus and fault inputs
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic HIGH_SUPPLY_IN,
  input wire logic LOW_SUPPLY_IN,
  input wire logic PUMP_LOW_IN,
  input wire logic OVER_TEMP_IN,
  input wire logic STEP_PIN_IN,
  // Outputs watched
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [1:0] BRIDGE_EN_OUT,
  input wire logic STEP_ADVANCE_OUT,
  input wire logic FAULT_PIN_O_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  // Five samples cover the two sync flops and the output flop
  high_off_a: assert property (HIGH_SUPPLY_IN [*5] |-> BRIDGE_EN_OUT == 2'b00)
    else $error("bridge on during high supply");
  low_off_a: assert property ((LOW_SUPPLY_IN || PUMP_LOW_IN) [*5] |-> BRIDGE_EN_OUT == 2'b00)
    else $error("bridge on during low supply");
  temp_off_a: assert property (OVER_TEMP_IN [*5] |-> BRIDGE_EN_OUT == 2'b00)
    else $error("bridge on during overtemperature");
  step_adv_a: assert property ($rose(STEP_PIN_IN) |-> ##[2:4] STEP_ADVANCE_OUT)
    else $error("step pin edge did not advance");
  adv_pulse_a: assert property (STEP_ADVANCE_OUT |=> !STEP_ADVANCE_OUT)
    else $error("advance longer than one cycle");
  apb_wait_a: assert property (PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN
    |-> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  pin_low_a: assert property (FAULT_PIN_O_OUT == 1'b0)
    else $error("fault pin driven high");
endmodule : sfs_chk

bind sfs_supervisor sfs_chk i_sfs_chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .HIGH_SUPPLY_IN(HIGH_SUPPLY_IN),
  .LOW_SUPPLY_IN(LOW_SUPPLY_IN), .PUMP_LOW_IN(PUMP_LOW_IN),
  .OVER_TEMP_IN(OVER_TEMP_IN), .STEP_PIN_IN(STEP_PIN_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .BRIDGE_EN_OUT(BRIDGE_EN_OUT), .STEP_ADVANCE_OUT(STEP_ADVANCE_OUT),
  .FAULT_PIN_O_OUT(FAULT_PIN_O_OUT)
);
`default_nettype wire

// File: dv/sfs_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller side of the fault pin
module sfs_mcu_model (
  // Pin from the driver
  input wire logic pin_o_in,
  input wire logic pin_oe_in,
  // Level the controller reads
  output logic pin_level_out
);
  // Pull-up holds a released line high, never the last driven value
  assign pin_level_out = pin_oe_in ? pin_o_in : 1'b1;
endmodule : sfs_mcu_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfs_consts.svh"
// ==========
// Self-checking bench
module tb_top;
  import sfs_pkg::*;
  localparam int BLK = 20;
  localparam logic [11:0] CFG = `SFS_OFF_CONFIG;
  localparam logic [11:0] ST = `SFS_OFF_STATUS;
  localparam logic [11:0] CMD = `SFS_OFF_CMD;
  localparam logic [11:0] LIVE = `SFS_OFF_LIVE;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, stp = 1'b0, seq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, cfg;
  logic [31:0] seed = 32'h0000_0822;
  logic [4:0] sup = 5'h00; // high, low, pump, heat, temp
  logic [1:0] oc = 2'h0, otm = 2'h0, clow = 2'h0, pwm = 2'h0, bren;
  logic [9:0] ta = 10'h000, tb = 10'h000;
  logic pready, pslverr, err, olvl, adv, pin_o, pin_oe, pin_wire;
  int errors = 0, total_checks = 0, cycles = 0;

  sfs_supervisor #(.BLANK_UNIT_CYC(BLK), .OPEN_UNIT_CYC(20)) i_sfs_supervisor (
    .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .HIGH_SUPPLY_IN(sup[0]),
    .LOW_SUPPLY_IN(sup[1]), .PUMP_LOW_IN(sup[2]), .HEAT_WARN_IN(sup[3]),
    .OVER_TEMP_IN(sup[4]), .OVERCURRENT_IN(oc), .ONTIME_MAX_IN(otm),
    .CURRENT_LOW_IN(clow), .PWM_THRESH_IN(pwm), .STEP_PIN_IN(stp),
    .SEQ_STEP_IN(seq), .TARGET_A_MA_IN(ta), .TARGET_B_MA_IN(tb),
    .BRIDGE_EN_OUT(bren), .OPEN_LEVEL_SEL_OUT(olvl), .STEP_ADVANCE_OUT(adv),
    .FAULT_PIN_O_OUT(pin_o), .FAULT_PIN_OE_OUT(pin_oe)
  );
  sfs_mcu_model i_sfs_mcu_model (.pin_o_in(pin_o), .pin_oe_in(pin_oe), .pin_level_out(pin_wire));

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int blank(input int s);
    return (s + 1) * BLK;
  endfunction : blank
  function automatic int st_bit(input int i);
    return (i < 2) ? i + 2 : i + 1;
  endfunction : st_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Held request until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ==========
  // Main sequence
  initial begin
    cyc(10);
    rstn <= 1'b1;
    cyc(5);
    apb(0, ST, 0);
    chk("status_reset", 32'h0000_0003, rd);
    apb(0, CFG, 0);
    chk("config_reset", 32'h0000_000A, rd);
    apb(0, 12'h010, 0);
    chk("unmapped_err", 1, err);
    seed = lfsr(seed);
    cfg = seed & 32'h0000_013F;
    apb(1, CFG, cfg);
    cyc(1);
    chk("open_level", cfg[5], olvl);
    for (int i = 0; i < 5; i++) begin
      sup[i] <= 1'b1;
      cyc(6);
      chk("bridge_fault", (i == 3) ? 2'b11 : 2'b00, bren);
      chk("pin_fault", 0, pin_wire);
      apb(0, CFG, 0);
      chk("config_kept", cfg, rd);
      sup[i] <= 1'b0;
      cyc(6);
      chk("bridge_back", 3, bren);
      chk("pin_back", 1, pin_wire);
      apb(0, ST, 0);
      chk("status_bit", 1, rd[st_bit(i)]);
      apb(1, ST, 32'h0000_03FF);
    end
    // Supply function ignores heat, follows low supply
    apb(1, CFG, 32'h0000_0040);
    sup[3] <= 1'b1;
    cyc(6);
    chk("pin_sup_heat", 1, pin_wire);
    sup[1] <= 1'b1;
    cyc(6);
    chk("pin_sup_low", 0, pin_wire);
    sup <= 5'h00;
    cyc(6);
    // Blanking either side of each delay, then retry by step
    for (int s = 0; s < 4; s++) begin
      apb(1, CFG, 32'(s));
      oc[0] <= 1'b1;
      cyc(blank(s) - 4);
      oc[0] <= 1'b0;
      cyc(5);
      chk("oc_short", 3, bren);
      oc[0] <= 1'b1;
      cyc(blank(s) + 6);
      oc[0] <= 1'b0;
      cyc(4);
      chk("oc_latched", 2, bren);
      seq <= 1'b1;
      cyc(1);
      seq <= 1'b0;
      cyc(4);
      chk("oc_retry", 3, bren);
    end
    apb(1, CFG, 32'h0000_0004);
    oc[1] <= 1'b1;
    cyc(30);
    oc[1] <= 1'b0;
    seq <= 1'b1;
    cyc(1);
    seq <= 1'b0;
    cyc(4);
    chk("oc_hold", 1, bren);
    otm[0] <= 1'b1;
    cyc(1);
    otm[0] <= 1'b0;
    cyc(5);
    chk("ontime", 0, bren);
    apb(1, CMD, 32'h0000_0001);
    cyc(3);
    chk("oc_cmd_reset", 3, bren);
    // Open load: phase B sits exactly at twice the threshold
    apb(1, CFG, 32'h0000_0000);
    seed = lfsr(seed);
    ta <= 10'h01B + {1'b0, seed[8:0]};
    tb <= 10'h01A;
    clow <= 2'b11;
    cyc(40);
    apb(0, LIVE, 0);
    chk("open_set", 1, rd[9:8]);
    chk("open_drive", 3, bren);
    stp <= 1'b1;
    for (int n = 0; n < 8 && adv !== 1'b1; n++) cyc(1);
    chk("advance", 1, adv);
    apb(0, LIVE, 0);
    chk("open_step", 0, rd[9:8]);
    stp <= 1'b0;
    cyc(30);
    apb(0, LIVE, 0);
    chk("open_relock", 1, rd[9:8]);
    clow <= 2'b00;
    cyc(6);
    apb(0, LIVE, 0);
    chk("open_recover", 0, rd[9:8]);
    apb(1, CFG, 32'h0000_0100);
    clow <= 2'b11;
    cyc(30);
    apb(1, CMD, 32'h0000_0002);
    apb(0, LIVE, 0);
    chk("open_inhibit", 1, rd[8]);
    // PWM threshold pulse comes while the lockout restarted by the single step is still running
    pwm[0] <= 1'b1;
    cyc(4);
    pwm[0] <= 1'b0;
    apb(0, LIVE, 0);
    chk("open_pwm", 0, rd[8]);
    apb(1, CFG, 32'h0000_0000);
    cyc(30);
    // Target at twice threshold, so nothing re-flags after the clear
    ta <= 10'h01A;
    apb(1, CMD, 32'h0000_0004);
    apb(0, LIVE, 0);
    chk("open_seq", 0, rd[8]);
    apb(1, CFG, 32'h0000_0020);
    ta <= 10'h028;
    cyc(40);
    chk("level_high", 1, olvl);
    apb(0, LIVE, 0);
    chk("open_level_hi", 0, rd[9:8]);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
